// ===== design/jtd_tap.sv
// test access port: tap controller, instruction decode, data registers
// Contract
// - four pins only: TCK, TMS, TDI from host, TDO from device.
// - capture, shift, update happen in the standard tap states.
// - 16-bit instruction register shifted between TDI and TDO.
// - three boundary-scan data registers, four memory access registers.
// - code 0000 routes the boundary register, pins under test control.
// - code 0004 selects the identification register.
// - code FFFF selects the one-stage bypass register.
// - code 0082 selects the memory access control register.
// - code 0083 selects the memory data port register.
// - code 0084 selects the memory target address register.
// - code 0085 selects the memory timing scale register.
// - code 0002 observes and presets boundary latches without driving.
// - during EXTEST all inputs to core logic are forced to one.
// - identification register is 32 bits, shifts a fixed value.
// - boundary register is a 134-bit shift register.
`timescale 1ns/1ps
module jtd_tap
    import jtd_pkg::*;
#(
    parameter int PIN_N = 8,
    parameter int CTL_W = 8,
    parameter int DAT_W = 8,
    parameter int ADR_W = 17,
    parameter int SCL_W = 8
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    input wire logic [BSR_LEN-1:0] BSC_CAPTURE,
    output logic [BSR_LEN-1:0] BSC_UPDATE,
    output logic BSC_DRIVE,
    input wire logic [PIN_N-1:0] PIN_IN,
    output logic [PIN_N-1:0] CORE_IN,
    input wire logic [DAT_W-1:0] NVM_RDATA,
    output logic [CTL_W-1:0] NVM_CTRL,
    output logic [DAT_W-1:0] NVM_WDATA,
    output logic NVM_WRITE,
    output logic [ADR_W-1:0] NVM_ADDR,
    output logic [SCL_W-1:0] NVM_SCALE
);
    logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2;
    logic [BSR_LEN-1:0] bsc_s1, bsc_s2;
    logic [PIN_N-1:0] pin_s1, pin_s2;
    logic tck_rise, tck_fall;
    jtd_tap_t state, next_state;
    jtd_path_t path;
    logic [IR_W-1:0] ir, ir_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [ID_W-1:0] id_sh;
    logic byp_sh;
    logic [CTL_W-1:0] ctl_sh;
    logic [DAT_W-1:0] dat_sh;
    logic [ADR_W-1:0] adr_sh;
    logic [SCL_W-1:0] scl_sh;
    logic dr_out;

    // pins and pads come from outside this clock, two stages each, three for tck
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b1;
            tdi_s2 <= 1'b1;
        end else begin
            tck_s1 <= TCK;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= TMS;
            tms_s2 <= tms_s1;
            tdi_s1 <= TDI;
            tdi_s2 <= tdi_s1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            bsc_s1 <= '0;
            bsc_s2 <= '0;
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            bsc_s1 <= BSC_CAPTURE;
            bsc_s2 <= bsc_s1;
            pin_s1 <= PIN_IN;
            pin_s2 <= pin_s1;
        end
    end

    // tms and tdi see the same delay as tck, so host setup holds
    assign tck_rise = tck_s2 & ~tck_s3;
    assign tck_fall = ~tck_s2 & tck_s3;

    always_comb begin
        next_state = state;
        case (state)
            TLR: next_state = tms_s2 ? TLR : RTI;
            RTI: next_state = tms_s2 ? SEL_DR : RTI;
            SEL_DR: next_state = tms_s2 ? SEL_IR : CAP_DR;
            CAP_DR: next_state = tms_s2 ? EX1_DR : SH_DR;
            SH_DR: next_state = tms_s2 ? EX1_DR : SH_DR;
            EX1_DR: next_state = tms_s2 ? UPD_DR : PAU_DR;
            PAU_DR: next_state = tms_s2 ? EX2_DR : PAU_DR;
            EX2_DR: next_state = tms_s2 ? UPD_DR : SH_DR;
            UPD_DR: next_state = tms_s2 ? SEL_DR : RTI;
            SEL_IR: next_state = tms_s2 ? TLR : CAP_IR;
            CAP_IR: next_state = tms_s2 ? EX1_IR : SH_IR;
            SH_IR: next_state = tms_s2 ? EX1_IR : SH_IR;
            EX1_IR: next_state = tms_s2 ? UPD_IR : PAU_IR;
            PAU_IR: next_state = tms_s2 ? EX2_IR : PAU_IR;
            EX2_IR: next_state = tms_s2 ? UPD_IR : SH_IR;
            UPD_IR: next_state = tms_s2 ? SEL_DR : RTI;
            default: next_state = TLR;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N)
            state <= TLR;
        else if (tck_rise)
            state <= next_state;
    end

    always_comb begin
        if (ir == OP_EXTEST || ir == OP_SAMPLE)
            path = P_BSR;
        else if (ir == OP_IDCODE)
            path = P_ID;
        else if (ir == OP_NVM_CTL)
            path = P_CTL;
        else if (ir == OP_NVM_DAT)
            path = P_DAT;
        else if (ir == OP_NVM_ADR)
            path = P_ADR;
        else if (ir == OP_NVM_SCL)
            path = P_SCL;
        else
            path = P_BYP;
    end

    // instruction shifter and latched instruction
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ir_sh <= '0;
            ir <= IR_RESET;
        end else if (tck_rise) begin
            case (state)
                TLR: ir <= IR_RESET;
                CAP_IR: ir_sh <= IR_CAPTURE;
                SH_IR: ir_sh <= {tdi_s2, ir_sh[IR_W-1:1]};
                UPD_IR: ir <= ir_sh;
                default: ir <= ir;
            endcase
        end
    end

    // each data register shifts only while its path is selected
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            bsr_sh <= '0;
            id_sh <= '0;
            byp_sh <= 1'b0;
        end else if (tck_rise && state == CAP_DR) begin
            if (path == P_BSR)
                bsr_sh <= bsc_s2;
            if (path == P_ID)
                id_sh <= ID_VALUE;
            if (path == P_BYP)
                byp_sh <= 1'b0;
        end else if (tck_rise && state == SH_DR) begin
            if (path == P_BSR)
                bsr_sh <= {tdi_s2, bsr_sh[BSR_LEN-1:1]};
            if (path == P_ID)
                id_sh <= {tdi_s2, id_sh[ID_W-1:1]};
            if (path == P_BYP)
                byp_sh <= tdi_s2;
        end
    end

    // memory access registers; their meaning lies beyond this block
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            ctl_sh <= '0;
            dat_sh <= '0;
            adr_sh <= '0;
            scl_sh <= '0;
        end else if (tck_rise && state == CAP_DR) begin
            if (path == P_CTL)
                ctl_sh <= NVM_CTRL;
            if (path == P_DAT)
                dat_sh <= NVM_RDATA;
            if (path == P_ADR)
                adr_sh <= NVM_ADDR;
            if (path == P_SCL)
                scl_sh <= NVM_SCALE;
        end else if (tck_rise && state == SH_DR) begin
            if (path == P_CTL)
                ctl_sh <= {tdi_s2, ctl_sh[CTL_W-1:1]};
            if (path == P_DAT)
                dat_sh <= {tdi_s2, dat_sh[DAT_W-1:1]};
            if (path == P_ADR)
                adr_sh <= {tdi_s2, adr_sh[ADR_W-1:1]};
            if (path == P_SCL)
                scl_sh <= {tdi_s2, scl_sh[SCL_W-1:1]};
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            NVM_CTRL <= '0;
            NVM_WDATA <= '0;
            NVM_WRITE <= 1'b0;
            NVM_ADDR <= '0;
            NVM_SCALE <= '0;
        end else begin
            NVM_WRITE <= 1'b0;
            if (tck_rise && state == UPD_DR) begin
                if (path == P_CTL)
                    NVM_CTRL <= ctl_sh;
                if (path == P_DAT) begin
                    NVM_WDATA <= dat_sh;
                    NVM_WRITE <= 1'b1;
                end
                if (path == P_ADR)
                    NVM_ADDR <= adr_sh;
                if (path == P_SCL)
                    NVM_SCALE <= scl_sh;
            end
        end
    end

    // update latches load under both codes; only EXTEST drives pins
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            BSC_UPDATE <= '0;
            BSC_DRIVE <= 1'b0;
            CORE_IN <= '0;
        end else begin
            if (tck_rise && state == UPD_DR && path == P_BSR)
                BSC_UPDATE <= bsr_sh;
            BSC_DRIVE <= (ir == OP_EXTEST);
            CORE_IN <= (ir == OP_EXTEST) ? '1 : pin_s2;
        end
    end

    always_comb begin
        case (path)
            P_BSR: dr_out = bsr_sh[0];
            P_ID: dr_out = id_sh[0];
            P_CTL: dr_out = ctl_sh[0];
            P_DAT: dr_out = dat_sh[0];
            P_ADR: dr_out = adr_sh[0];
            P_SCL: dr_out = scl_sh[0];
            default: dr_out = byp_sh;
        endcase
    end

    // tdo changes on the falling tck edge so the host samples it stable
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            TDO <= 1'b0;
            TDO_OE <= 1'b0;
        end else if (tck_fall) begin
            TDO <= (state == SH_IR) ? ir_sh[0] : dr_out;
            TDO_OE <= (state == SH_IR || state == SH_DR);
        end
    end

    AST_TLR_RESETS_IR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (tck_rise && state == TLR) |=> ir == IR_RESET)
        else $error("instruction not reset in test logic reset");
    AST_IR_SHIFT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (tck_rise && state == SH_IR)
        |=> ir_sh == {$past(tdi_s2), $past(ir_sh[IR_W-1:1])})
        else $error("instruction shift wrong");
    AST_EXTEST_PATH: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (tck_rise && state == UPD_IR && ir_sh == OP_EXTEST)
        |=> path == P_BSR ##1 BSC_DRIVE)
        else $error("extest did not select boundary");
    AST_IDCODE_CAPTURE: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        (tck_rise && state == CAP_DR && ir == OP_IDCODE)
        |=> id_sh == ID_VALUE)
        else $error("idcode value not captured");
    AST_BYPASS_ONE_STAGE: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        (tck_rise && state == SH_DR && ir == OP_BYPASS)
        |=> byp_sh == $past(tdi_s2))
        else $error("bypass not one stage");
    AST_CTL_UPDATE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (tck_rise && state == UPD_DR && ir == OP_NVM_CTL)
        |=> NVM_CTRL == $past(ctl_sh))
        else $error("control register not updated");
    AST_DAT_WRITE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (tck_rise && state == UPD_DR && ir == OP_NVM_DAT)
        |=> NVM_WRITE ##1 !NVM_WRITE)
        else $error("data write strobe wrong");
    AST_ADR_UPDATE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (tck_rise && state == UPD_DR && ir == OP_NVM_ADR)
        |=> NVM_ADDR == $past(adr_sh))
        else $error("address register not updated");
    AST_SCL_UPDATE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (tck_rise && state == UPD_DR && ir == OP_NVM_SCL)
        |=> NVM_SCALE == $past(scl_sh))
        else $error("scale register not updated");
    AST_SAMPLE_NO_DRIVE: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        (ir == OP_SAMPLE) [*2] |-> !BSC_DRIVE)
        else $error("sample drove the pins");
    AST_EXTEST_FORCE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (ir == OP_EXTEST) [*2] |-> CORE_IN == '1)
        else $error("core inputs not forced high");
    AST_UNKNOWN_BYPASS: assert property (@(posedge REF_CLK)
        disable iff (!RST_N)
        (tck_rise && state == UPD_IR && ir_sh == 16'h0001)
        |=> path == P_BYP)
        else $error("unknown code not bypass");
    AST_BSR_SHIFT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (tck_rise && state == SH_DR && path == P_BSR)
        |=> bsr_sh[BSR_LEN-1] == $past(tdi_s2))
        else $error("boundary shift wrong");

    COV_IR_LOAD: cover property (@(posedge REF_CLK)
        tck_rise && state == UPD_IR);
    COV_ID_SHIFT: cover property (@(posedge REF_CLK)
        tck_rise && state == SH_DR && path == P_ID);
    COV_NVM_WRITE: cover property (@(posedge REF_CLK) NVM_WRITE);
    COV_EXTEST_DRIVE: cover property (@(posedge REF_CLK)
        BSC_DRIVE && state == UPD_DR);
endmodule

// ===== design/jtd_pkg.sv
// constants for the test access port instruction decode block
package jtd_pkg;
    localparam int IR_W = 16;
    localparam logic [15:0] IR_RESET = 16'h0000;
    localparam logic [15:0] IR_CAPTURE = 16'h0001;
    localparam logic [15:0] OP_EXTEST = 16'h0000;
    localparam logic [15:0] OP_SAMPLE = 16'h0002;
    localparam logic [15:0] OP_IDCODE = 16'h0004;
    localparam logic [15:0] OP_BYPASS = 16'hFFFF;
    localparam logic [15:0] OP_NVM_CTL = 16'h0082;
    localparam logic [15:0] OP_NVM_DAT = 16'h0083;
    localparam logic [15:0] OP_NVM_ADR = 16'h0084;
    localparam logic [15:0] OP_NVM_SCL = 16'h0085;
    localparam int BSR_LEN = 134;
    localparam int ID_W = 32;
    // arbitrary identification value
    localparam logic [31:0] ID_VALUE = 32'h1234_5001;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR,
        UPD_DR, SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } jtd_tap_t;

    typedef enum logic [2:0] {
        P_BSR, P_ID, P_BYP, P_CTL, P_DAT, P_ADR, P_SCL
    } jtd_path_t;
endpackage

// ===== sim/jtd_host_model.sv
// behavioural test host driving tck, tms and tdi and sampling tdo
`timescale 1ns/1ps
module jtd_host_model (
    input wire logic ref_clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // 40 ns for the high half of the test clock, 45 ns for the low half
    localparam int HALF = 8;

    // test clock stands low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one test clock: mode and data change only while tck is low
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge ref_clk);
        tms = m;
        tdi = d;
        repeat (HALF) @(negedge ref_clk);
        tck = 1'b1;
        q = tdo;
        repeat (HALF) @(negedge ref_clk);
        tck = 1'b0;
    endtask

    // data line toggles outside shifts, so a stale bit never looks valid
    task automatic walk(input logic m);
        logic q;
        step(m, ~tdi, q);
    endtask

    task automatic tap_reset();
        repeat (5) walk(1'b1);
        walk(1'b0);
    endtask

    // from idle: select, capture, shift n bits lsb first, update, idle
    task automatic scan(input logic ir, input int n,
                        input logic [133:0] din, output logic [133:0] dout);
        logic q;
        dout = '0;
        walk(1'b1);
        if (ir) begin
            walk(1'b1);
        end
        walk(1'b0);
        walk(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        walk(1'b1);
        walk(1'b0);
    endtask
endmodule

// ===== sim/jtag_tap_instruction_decode_bench.sv
// self-checking bench for the test access port block
`timescale 1ns/1ps
module jtag_tap_instruction_decode_bench;
    import jtd_pkg::*;
    localparam logic [133:0] PAT_A = {2'h1, {11{12'h8e4}}};
    localparam logic [133:0] PAT_B = {2'h2, {11{12'h35a}}};
    localparam logic [133:0] PAT_C = {2'h3, {11{12'h1c7}}};
    logic ref_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, bsc_drive, nvm_write;
    logic [BSR_LEN-1:0] bsc_capture, bsc_update;
    logic [7:0] pin_in, core_in, nvm_rdata, nvm_ctrl, nvm_wdata, nvm_scale;
    logic [16:0] nvm_addr;
    logic [133:0] got;
    logic [15:0] byp [3] = '{OP_BYPASS, 16'h1234, 16'h0001};
    logic [15:0] mem [4] = '{OP_NVM_CTL, OP_NVM_DAT, OP_NVM_ADR, OP_NVM_SCL};
    int wid [4] = '{8, 8, 17, 8};
    logic [133:0] v1 [4] = '{134'h5c, 134'h71, 134'h1_a2c3, 134'he9};
    logic [133:0] v2 [4] = '{134'ha3, 134'h0f, 134'h0_5d3c, 134'h16};
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    int n_write = 0;
    // one output-enable window per shift frame, low between frames
    int n_oe = 0;
    logic oe_last = 1'b0;

    jtd_tap i_jtd_tap (.REF_CLK(ref_clk), .RST_N(rst_n), .TCK(tck),
        .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
        .BSC_CAPTURE(bsc_capture), .BSC_UPDATE(bsc_update),
        .BSC_DRIVE(bsc_drive), .PIN_IN(pin_in), .CORE_IN(core_in),
        .NVM_RDATA(nvm_rdata), .NVM_CTRL(nvm_ctrl), .NVM_WDATA(nvm_wdata),
        .NVM_WRITE(nvm_write), .NVM_ADDR(nvm_addr), .NVM_SCALE(nvm_scale));

    jtd_host_model u_host (.ref_clk(ref_clk), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // a level stuck high would count more than once
    always @(posedge ref_clk) begin
        if (nvm_write === 1'b1) begin
            n_write++;
        end
        if (tdo_oe === 1'b1 && oe_last !== 1'b1) begin
            n_oe++;
        end
        oe_last = tdo_oe;
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [133:0] a, input logic [133:0] e);
        checks_done++;
        if (a !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask

    task automatic load_ir(input logic [15:0] code);
        u_host.scan(1'b1, IR_W, {118'h0, code}, got);
        chk(got, IR_CAPTURE);
    endtask

    task automatic dr(input int n, input logic [133:0] din);
        u_host.scan(1'b0, n, din, got);
    endtask

    initial begin
        rst_n = 1'b0;
        bsc_capture = PAT_A;
        pin_in = 8'h5a;
        nvm_rdata = 8'h3c;
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk({bsc_drive, core_in}, {1'b1, 8'hff});
        u_host.tap_reset();
        load_ir(OP_EXTEST);
        dr(BSR_LEN, PAT_B);
        chk(got, PAT_A);
        chk(bsc_update, PAT_B);
        chk({bsc_drive, core_in}, {1'b1, 8'hff});
        bsc_capture = PAT_C;
        pin_in = 8'ha3;
        load_ir(OP_SAMPLE);
        dr(BSR_LEN, PAT_A);
        chk(got, PAT_C);
        chk(bsc_update, PAT_A);
        chk({bsc_drive, core_in}, {1'b0, 8'ha3});
        // one extra bit proves the register length
        load_ir(OP_IDCODE);
        dr(ID_W + 1, 134'h1);
        chk(got, {1'b1, ID_VALUE});
        foreach (byp[k]) begin
            load_ir(byp[k]);
            dr(8, 134'hb5);
            chk(got, 134'h6a);
        end
        foreach (mem[k]) begin
            load_ir(mem[k]);
            dr(wid[k], v1[k]);
            dr(wid[k], v2[k]);
            chk(got, (k == 1) ? 134'h3c : v1[k]);
        end
        chk(nvm_ctrl, v2[0]);
        chk(nvm_wdata, v2[1]);
        chk(n_write, 2);
        chk(nvm_addr, v2[2]);
        chk(nvm_scale, v2[3]);
        chk(tdo_oe, 1'b0);
        chk(n_oe, 24);
        load_ir(OP_BYPASS);
        u_host.tap_reset();
        repeat (4) @(negedge ref_clk);
        chk({bsc_drive, core_in}, {1'b1, 8'hff});
        conclude();
    end
endmodule
